/* File: design/tsmx_defs.svh */
// Purpose: opcodes, reset values and timing constants of the executor
// Assumes: 10-bit instruction words, 4-bit accumulator
// Notes: definitions only
`ifndef TSMX_DEFS_SVH
`define TSMX_DEFS_SVH

// single-word opcodes
`define TSMX_OP_NOP 10'h000
`define TSMX_OP_HI_FROM_ACC 10'h0BF
`define TSMX_OP_LO_FROM_ACC 10'h09F
`define TSMX_OP_T_IND 10'h0FF
`define TSMX_OP_CARRY_RUN 10'h02B
`define TSMX_OP_ACC_FROM_HI 10'h0BE
`define TSMX_OP_ACC_FROM_LO 10'h09E
// register-form status test: upper six bits, low four pick the register
`define TSMX_OP_TEST_REG 6'h06
// two-word opcodes
`define TSMX_OP_T_IMM 10'h0DF
`define TSMX_OP_HALT 10'h051
`define TSMX_OP_TEST_IMM 10'h071

// reset values and steps
`define TSMX_PC_RESET 10'h000
`define TSMX_PC_ONE 10'h001
`define TSMX_PC_TWO 10'h002
`define TSMX_NIB_ZERO 4'h0
`define TSMX_NIB_ALL 4'hF
`define TSMX_TIMER_RESET 10'h000
`define TSMX_INTERVAL_ONE 15'h0001

// timer interval: oscillator periods per count, plain and as log2 shifts
`define TSMX_FAST_PERIODS 8
`define TSMX_SLOW_PERIODS 16
`define TSMX_FAST_SHIFT 4'h3
`define TSMX_SLOW_SHIFT 4'h4

`endif

/* File: design/tsmx_pkg.sv */
// Purpose: shared types of the timer/status/misc instruction executor
// Assumes: defs header carries all numbers except the state encodings set here
// Notes: struct layouts fix every field position
package tsmx_pkg;
  typedef enum logic [2:0] {
    S_DECODE = 3'b000,
    S_OPERAND = 3'b001,
    S_INDIRECT = 3'b010,
    S_REGTEST = 3'b011,
    S_STANDBY = 3'b100
  } tsmx_state_type;

  // timer register, bits 9..6, 5..2, 1, 0
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
    logic bit1;
    logic bit0;
  } tsmx_timer_type;

  // timer image in an operand or table word, msb first
  typedef struct packed {
    logic bit1;
    logic [3:0] hi;
    logic bit0;
    logic [3:0] lo;
  } tsmx_timer_word_type;

  // immediate nibble operand and register-select form
  typedef struct packed {
    logic [5:0] upper;
    logic [3:0] data;
  } tsmx_nibble_word_type;

  // pins that need synchronising
  typedef struct packed {
    logic sense0;
    logic sense1;
    logic [7:0] key_bidir;
    logic [3:0] key_input;
  } tsmx_pins_type;
endpackage

/* File: design/tsmx_exec.sv */
// Purpose: executes timer-load, standby, status-test, carry-set and nop
// Assumes: program memory reads combinationally from rom_addr
// Notes: timer counting and standby release live outside this block
`timescale 1ns/100ps
`include "tsmx_defs.svh"

module tsmx_exec
  import tsmx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  output logic [9:0] rom_addr,
  input wire logic [9:0] rom_data,
  input wire logic [1:0] rom_page_select_reg,
  input wire logic [7:0] rom_pointer_pair,
  output logic [3:0] reg_sel,
  input wire logic [3:0] reg_data,
  input wire logic acc_load,
  input wire logic [3:0] acc_load_value,
  input wire logic sense_input_zero,
  input wire logic sense_input_one,
  input wire logic [7:0] key_bidir_pins,
  input wire logic [3:0] key_input_pins,
  input wire logic timer_done,
  input wire logic timer_clk_sel,
  input wire logic standby_release,
  output logic [3:0] accumulator,
  output logic carry_bit,
  output logic match_flag,
  output tsmx_timer_type timer_value,
  output logic timer_loaded,
  output logic [14:0] interval_cycles,
  output logic standby,
  output logic [3:0] wake_mask
);
  tsmx_state_type state, next_state;
  logic [9:0] pc, next_pc, next_rom_addr, op, next_op;
  logic [3:0] next_reg_sel, next_acc, next_wake;
  logic next_carry, next_match, next_load, next_standby;
  tsmx_timer_type next_timer;
  tsmx_pins_type pins_meta, pins_sync;

  // any enabled status coincides with a set mask bit
  function automatic logic status_hit(input logic [3:0] mask,
                                      input logic [3:0] stat);
    return |(mask & stat);
  endfunction

  // pins are asynchronous: two flops before use
  always_ff @(posedge sys_clk) begin
    pins_meta <= {sense_input_zero, sense_input_one, key_bidir_pins,
                  key_input_pins};
    pins_sync <= pins_meta;
  end

  // decode of the word on the memory bus and of the synchronised pins
  tsmx_timer_word_type word_timer;
  tsmx_nibble_word_type word_nib;
  wire [3:0] status_bits;
  wire [9:0] pc_plus1, pc_plus2;
  wire [3:0] run_value;
  wire dec_t1a, dec_t0a, dec_at1, dec_at0, dec_carry, dec_ind, dec_sreg;
  wire dec_two;
  assign word_timer = rom_data;
  assign word_nib = rom_data;
  assign pc_plus1 = pc + `TSMX_PC_ONE;
  assign pc_plus2 = pc + `TSMX_PC_TWO;
  assign dec_t1a = rom_data == `TSMX_OP_HI_FROM_ACC;
  assign dec_t0a = rom_data == `TSMX_OP_LO_FROM_ACC;
  assign dec_at1 = rom_data == `TSMX_OP_ACC_FROM_HI;
  assign dec_at0 = rom_data == `TSMX_OP_ACC_FROM_LO;
  assign dec_carry = rom_data == `TSMX_OP_CARRY_RUN;
  assign dec_ind = rom_data == `TSMX_OP_T_IND;
  assign dec_sreg = word_nib.upper == `TSMX_OP_TEST_REG;
  assign dec_two = rom_data == `TSMX_OP_T_IMM ||
                   rom_data == `TSMX_OP_HALT ||
                   rom_data == `TSMX_OP_TEST_IMM;
  // bit0 sense pins, bit1 key i/o, bit2 key inputs, bit3 timer
  assign status_bits = {timer_done, |pins_sync.key_input,
                        |pins_sync.key_bidir,
                        pins_sync.sense0 | pins_sync.sense1};
  // keep the unbroken run of ones from bit 0
  assign run_value = !accumulator[0] ? 4'h0 :
                      !accumulator[1] ? 4'h1 :
                      !accumulator[2] ? 4'h3 :
                      !accumulator[3] ? 4'h7 : `TSMX_NIB_ALL;

  // next-state and execute; the core's own acc writes lose to ours
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_rom_addr = rom_addr;
    next_op = op;
    next_reg_sel = reg_sel;
    next_acc = acc_load ? acc_load_value : accumulator;
    next_carry = carry_bit;
    next_match = match_flag;
    next_timer = timer_value;
    next_load = 1'b0;
    next_standby = standby;
    next_wake = wake_mask;
    case (state)
      S_DECODE: begin
        next_op = rom_data;
        next_pc = pc_plus1;
        next_rom_addr = pc_plus1;
        if (dec_t1a) begin
          next_timer.hi = accumulator;
          next_timer.bit1 = 1'b0;
          next_load = 1'b1;
        end else if (dec_t0a) begin
          next_timer.lo = accumulator;
          next_timer.bit0 = 1'b0;
          next_load = 1'b1;
        end else if (dec_at1) begin
          next_acc = timer_value.hi;
        end else if (dec_at0) begin
          next_acc = timer_value.lo;
        end else if (dec_carry) begin
          next_carry = accumulator == `TSMX_NIB_ALL;
          next_acc = run_value;
        end else if (dec_ind) begin
          // table word fetched from page and pointer pair
          next_pc = pc;
          next_rom_addr = {rom_page_select_reg, rom_pointer_pair};
          next_state = S_INDIRECT;
        end else if (dec_sreg) begin
          next_pc = pc;
          next_rom_addr = pc;
          next_reg_sel = word_nib.data;
          next_state = S_REGTEST;
        end else if (dec_two) begin
          // operand sits at the next address
          next_pc = pc;
          next_state = S_OPERAND;
        end
      end
      S_OPERAND: begin
        next_pc = pc_plus2;
        next_rom_addr = pc_plus2;
        next_state = S_DECODE;
        if (op == `TSMX_OP_T_IMM) begin
          next_timer = {word_timer.hi, word_timer.lo,
                        word_timer.bit1, word_timer.bit0};
          next_load = 1'b1;
        end else if (op == `TSMX_OP_TEST_IMM) begin
          next_match = status_hit(word_nib.data, status_bits);
        end else begin
          next_wake = word_nib.data;
          next_standby = 1'b1;
          next_state = S_STANDBY;
        end
      end
      S_INDIRECT: begin
        next_timer = {word_timer.hi, word_timer.lo,
                      word_timer.bit1, word_timer.bit0};
        next_load = 1'b1;
        next_pc = pc_plus1;
        next_rom_addr = pc_plus1;
        next_state = S_DECODE;
      end
      S_REGTEST: begin
        next_match = status_hit(reg_data, status_bits);
        next_pc = pc_plus1;
        next_rom_addr = pc_plus1;
        next_state = S_DECODE;
      end
      S_STANDBY: begin
        // release decision is made outside from wake_mask
        if (standby_release) begin
          next_standby = 1'b0;
          next_state = S_DECODE;
        end
      end
      default: begin
        next_state = S_DECODE;
      end
    endcase
  end

  // sequencing registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= S_DECODE;
      pc <= `TSMX_PC_RESET;
      rom_addr <= `TSMX_PC_RESET;
      op <= `TSMX_OP_NOP;
      reg_sel <= `TSMX_NIB_ZERO;
    end else begin
      state <= next_state;
      pc <= next_pc;
      rom_addr <= next_rom_addr;
      op <= next_op;
      reg_sel <= next_reg_sel;
    end
  end

  // architectural state seen by the rest of the core
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      accumulator <= `TSMX_NIB_ZERO;
      carry_bit <= 1'b0;
      match_flag <= 1'b0;
      timer_value <= `TSMX_TIMER_RESET;
      timer_loaded <= 1'b0;
      standby <= 1'b0;
      wake_mask <= `TSMX_NIB_ZERO;
    end else begin
      accumulator <= next_acc;
      carry_bit <= next_carry;
      match_flag <= next_match;
      timer_value <= next_timer;
      timer_loaded <= next_load;
      standby <= next_standby;
      wake_mask <= next_wake;
    end
  end

  // interval lags the timer by one cycle; fine for a count start
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      interval_cycles <= `TSMX_INTERVAL_ONE;
    end else begin
      interval_cycles <= ({5'h00, timer_value} + `TSMX_INTERVAL_ONE) <<
        (timer_clk_sel ? `TSMX_SLOW_SHIFT : `TSMX_FAST_SHIFT);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence two_word_issue(logic [9:0] code);
    state == S_DECODE && rom_data == code;
  endsequence

  nib_move_a: assert property (
    state == S_DECODE && dec_t1a |=>
      timer_value.hi == $past(accumulator) && !timer_value.bit1 &&
      timer_value.lo == $past(timer_value.lo))
    else $error("upper nibble move wrong");
  low_bit_a: assert property (
    state == S_DECODE && dec_t0a |=>
      timer_value.lo == $past(accumulator) && !timer_value.bit0)
    else $error("lower nibble move wrong");
  imm_load_a: assert property (
    two_word_issue(`TSMX_OP_T_IMM) ##1 1'b1 |=>
      timer_value == {$past(word_timer.hi), $past(word_timer.lo),
                      $past(word_timer.bit1), $past(word_timer.bit0)})
    else $error("immediate timer load wrong");
  interval_a: assert property (
    $stable(timer_value) && $stable(timer_clk_sel) |=>
      interval_cycles == ($past(timer_clk_sel) ?
        ({5'h00, $past(timer_value)} + 15'h0001) * `TSMX_SLOW_PERIODS :
        ({5'h00, $past(timer_value)} + 15'h0001) * `TSMX_FAST_PERIODS))
    else $error("timer interval wrong");
  ind_load_a: assert property (
    state == S_DECODE && dec_ind |=>
      rom_addr == {$past(rom_page_select_reg), $past(rom_pointer_pair)}
      ##1 timer_loaded)
    else $error("indirect timer load wrong");
  standby_a: assert property (
    two_word_issue(`TSMX_OP_HALT) ##1 1'b1 |=>
      standby && wake_mask == $past(word_nib.data) ##1 $stable(rom_addr))
    else $error("standby entry wrong");
  reg_test_a: assert property (
    state == S_REGTEST |=>
      match_flag == |($past(reg_data) & $past(status_bits)))
    else $error("register status test wrong");
  imm_test_a: assert property (
    state == S_OPERAND && op == `TSMX_OP_TEST_IMM |=>
      match_flag == |($past(word_nib.data) & $past(status_bits)))
    else $error("immediate status test wrong");
  carry_set_a: assert property (
    state == S_DECODE && dec_carry |=>
      carry_bit == ($past(accumulator) == 4'hF) &&
      accumulator == ($past(accumulator) & ~($past(accumulator) + 4'h1)))
    else $error("carry set wrong");
  timer_read_a: assert property (
    state == S_DECODE && dec_at1 && !acc_load |=>
      accumulator == $past(timer_value.hi))
    else $error("timer read wrong");
  pc_step_a: assert property (
    two_word_issue(`TSMX_OP_TEST_IMM) |=> ##1
      rom_addr == $past(pc, 2) + 10'h002 && state == S_DECODE)
    else $error("two-word step wrong");
endmodule

/* File: bench/tsmx_exec_test.sv */
// Purpose: self-checking bench of the timer/status/misc executor
// Assumes: program memory and register file answer combinationally
// Notes: each scenario runs a short program that ends in standby
`timescale 1ns/100ps
`include "tsmx_defs.svh"
module tsmx_exec_test
  import tsmx_pkg::*;
;
  typedef struct packed {
    logic [3:0] acc;
    logic carry;
    logic m;
    logic [3:0] wake;
    logic [14:0] iv;
    logic [9:0] pc;
  } tsmx_note_type;
  logic sys_clk = 0, resetn = 0, acc_load = 0, sense_a = 0, sense_b = 0;
  logic timer_done = 0, clk_sel = 0, rel = 0, prev_sb = 0;
  logic [3:0] acc_v = 0, kin = 0, accumulator, reg_sel, wake_mask, d, st, mk;
  logic [3:0] n;
  logic [7:0] kb = 0, ptr = 0;
  logic [1:0] page = 0;
  logic [9:0] rom_addr, w, mem [0:1023];
  logic [3:0] regs [0:15];
  logic carry_bit, match_flag, timer_loaded, standby;
  logic [14:0] interval_cycles;
  tsmx_timer_type timer_value, exp_t, e;
  tsmx_timer_type tq [$];
  tsmx_note_type sq [$];
  tsmx_note_type sn;
  integer seed = 36;
  int errors = 0, n_tests = 0, cycles = 0;

  tsmx_exec u_tsmx_exec (.sys_clk(sys_clk), .resetn(resetn),
    .rom_addr(rom_addr), .rom_data(mem[rom_addr]),
    .rom_page_select_reg(page), .rom_pointer_pair(ptr), .reg_sel(reg_sel),
    .reg_data(regs[reg_sel]), .acc_load(acc_load), .acc_load_value(acc_v),
    .sense_input_zero(sense_a), .sense_input_one(sense_b),
    .key_bidir_pins(kb), .key_input_pins(kin), .timer_done(timer_done),
    .timer_clk_sel(clk_sel), .standby_release(rel),
    .accumulator(accumulator), .carry_bit(carry_bit),
    .match_flag(match_flag), .timer_value(timer_value),
    .timer_loaded(timer_loaded), .interval_cycles(interval_cycles),
    .standby(standby), .wake_mask(wake_mask));

  // 40 MHz clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic cmp(input string what, input logic [14:0] ex,
    input logic [14:0] got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, ex, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // operand word msb first: t1, t9..t6, t0, t5..t2
  function automatic tsmx_timer_type fromw(input logic [9:0] x);
    fromw = {x[8:5], x[3:0], x[9], x[4]};
  endfunction

  // watcher: each load pulse and each entry to standby takes one note
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test;
    end
    if (resetn === 1'b1 && timer_loaded === 1'b1) begin
      e = (tq.size() > 0) ? tq.pop_front() : 'x;
      cmp("timer", {5'h00, e}, {5'h00, timer_value});
    end
    if (standby === 1'b1 && prev_sb !== 1'b1) begin
      sn = (sq.size() > 0) ? sq.pop_front() : 'x;
      cmp("acc", {11'h000, sn.acc}, {11'h000, accumulator});
      cmp("carry", {14'h0000, sn.carry}, {14'h0000, carry_bit});
      cmp("match", {14'h0000, sn.m}, {14'h0000, match_flag});
      cmp("wake", {11'h000, sn.wake}, {11'h000, wake_mask});
      cmp("interval", sn.iv, interval_cycles);
      cmp("pc", {5'h00, sn.pc}, {5'h00, rom_addr});
    end
    prev_sb = standby;
  end

  // fresh program space, all no-operation
  task automatic clear;
    foreach (mem[i]) mem[i] = `TSMX_OP_NOP;
    exp_t = '0;
    d = $random(seed);
    clk_sel = $random(seed);
  endtask

  task automatic load(input logic [9:0] a, b, c, f, g, h, j, k);
    mem[0] = a;
    mem[1] = b;
    mem[2] = c;
    mem[3] = f;
    mem[4] = g;
    mem[5] = h;
    mem[6] = j;
    mem[7] = k;
  endtask

  // interval is derived from the model timer, not the design's
  task automatic note(input logic [3:0] a, input logic cf, m,
    input logic [9:0] pc);
    sq.push_back({a, cf, m, d, ({5'h00, exp_t} + 15'h0001) *
      (clk_sel ? 15'h0010 : 15'h0008), pc});
  endtask

  // reset, preload the accumulator on the first live edge, run to standby
  task automatic run(input string name);
    resetn = 0;
    acc_load = 1;
    repeat (8) @(posedge sys_clk);
    #2 resetn = 1;
    @(posedge sys_clk);
    #2 acc_load = 0;
    while (standby !== 1'b1) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    cmp("standby held", 15'h0001, {14'h0000, standby});
    #2 rel = 1;
    @(posedge sys_clk);
    #2 rel = 0;
    repeat (2) @(posedge sys_clk);
    cmp("standby left", 15'h0000, {14'h0000, standby});
    cmp("notes left", 15'h0000, 15'(tq.size() + sq.size()));
    $display("test %s done", name);
    #2;
  endtask

  initial begin
    clear;
    // immediate load, then nibble moves around a nibble read
    repeat (3) begin
      clear;
      w = $random(seed) | 10'h210; // t1, t0 set so each move changes it
      acc_v = $random(seed);
      load(`TSMX_OP_NOP, `TSMX_OP_T_IMM, w, `TSMX_OP_HI_FROM_ACC,
        `TSMX_OP_ACC_FROM_LO, `TSMX_OP_LO_FROM_ACC, `TSMX_OP_HALT,
        {6'h00, d});
      exp_t = fromw(w);
      tq.push_back(exp_t);
      exp_t.hi = acc_v;
      exp_t.bit1 = 1'b0;
      tq.push_back(exp_t);
      exp_t.bit0 = 1'b0;
      tq.push_back(exp_t);
      note(exp_t.lo, 1'b0, 1'b0, 10'h008);
      run("nibble moves");
    end
    // indirect load from a page above the program, then upper nibble read
    repeat (3) begin
      clear;
      w = $random(seed) | 10'h001;
      page = 2'h1 + {1'b0, w[5]};
      ptr = $random(seed);
      load(`TSMX_OP_T_IND, `TSMX_OP_ACC_FROM_HI, `TSMX_OP_HALT, {6'h00, d},
        `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP);
      mem[{page, ptr}] = w;
      exp_t = fromw(w);
      tq.push_back(exp_t);
      note(exp_t.hi, 1'b0, 1'b0, 10'h004);
      run("indirect load");
    end
    // status tests, immediate and register form in turn
    for (int i = 0; i < 10; i++) begin
      clear;
      st = $random(seed);
      mk = $random(seed);
      n = $random(seed);
      w = $random(seed);
      sense_a = st[0] & w[0];
      sense_b = st[0] & ~w[0];
      kb = st[1] ? (8'h01 << w[3:1]) : 8'h00;
      kin = st[2] ? (4'h1 << w[5:4]) : 4'h0;
      timer_done = st[3];
      foreach (regs[j]) regs[j] = ~mk;
      regs[n] = mk;
      if (i[0]) begin
        load({`TSMX_OP_TEST_REG, n}, `TSMX_OP_HALT, {6'h00, d},
          `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP,
          `TSMX_OP_NOP);
        note(acc_v, 1'b0, |(st & mk), 10'h003);
      end else begin
        load(`TSMX_OP_TEST_IMM, {6'h00, mk}, `TSMX_OP_HALT, {6'h00, d},
          `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP);
        note(acc_v, 1'b0, |(st & mk), 10'h004);
      end
      run("status test");
    end
    // carry-set over every accumulator value
    for (int v = 0; v < 16; v++) begin
      clear;
      acc_v = v[3:0];
      load(`TSMX_OP_NOP, `TSMX_OP_CARRY_RUN, `TSMX_OP_HALT, {6'h00, d},
        `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP, `TSMX_OP_NOP);
      note(acc_v & ~(acc_v + 4'h1), acc_v == 4'hF, 1'b0, 10'h004);
      run("carry set");
    end
    end_of_test;
  end
endmodule
